/* File: bench/fwsr_flash_model.sv */
`timescale 1ns/1ps
module fwsr_flash_model import fwsr_pkg::*; #(
	parameter int BUSY_CYC = 60,
	parameter int PROT_CYC = 20
) (
	// Timer clock and protect strap.
	input wire logic clk,
	input wire logic prot,
	// Flash pins.
	input wire logic [21:0] flash_addr,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	output logic [7:0] bus,
	output logic ready_busy_n
);
	logic [7:0] mem [logic [21:0]];
	logic [47:0] hist = '0;
	logic [21:0] pa = '0;
	logic [7:0] pd = '0;
	logic [7:0] last = '0;
	logic run = 0, ers = 0, bad = 0, prt = 0, t1 = 0, t2 = 0, t5 = 0;
	int cnt = 0;
	wire rd_act = !flash_ce_n && !flash_oe_n;
	function automatic logic [7:0] arr(input logic [21:0] ad);
		return mem.exists(ad) ? mem[ad] : 8'hff;
	endfunction
	always @(posedge flash_we_n) if (!flash_ce_n && (!run || t5)) begin
		hist = {hist[39:0], flash_dq_o};
		if (flash_dq_o == CMD_RESET) begin
			run = 0;
			t5 = 0;
			hist = '0;
		end else if (hist[31:8] == 24'haa_55a0 || hist == 48'haa55_80aa_5530) begin
			ers = hist[31:8] != 24'haa_55a0;
			pa = flash_addr;
			pd = flash_dq_o;
			prt = prot;
			bad = !ers && !prot && |(flash_dq_o & ~arr(flash_addr));
			run = 1;
			cnt = 0;
			hist = '0;
		end
	end
	// A protected target only shows status for the short window, then nothing changes.
	always @(posedge clk) if (run && !t5) begin
		cnt++;
		if (cnt == (prt ? PROT_CYC : BUSY_CYC)) begin
			if (bad) begin
				t5 = 1;
			end else begin
				run = 0;
				// Erase ignores the sector address in pa and clears the whole array.
				if (!prt && ers) mem.delete();
				else if (!prt) mem[pa] = pd & arr(pa);
			end
		end
	end
	// This host never suspends an erase, so toggling stops only when the operation ends.
	always @(posedge rd_act) if (run) begin
		t1 = ~t1;
		if (ers && flash_addr[21:12] == pa[21:12]) t2 = ~t2;
	end
	// A released bus shows the inverse of the last byte rather than holding it.
	always @(negedge rd_act) last = bus;
	always @* begin
		if (flash_dq_oe) bus = flash_dq_o;
		else if (rd_act && run) bus = {ers ? 1'b0 : ~pd[7], t1, t5, 1'b0, ers, t2, 2'b00};
		else if (rd_act) bus = arr(flash_addr);
		else bus = ~last;
	end
	assign ready_busy_n = !run;
endmodule

/* File: bench/test_fwsr_host.sv */
`timescale 1ns/1ps
module test_fwsr_host import fwsr_pkg::*; ();
	typedef struct {logic [31:0] v; logic [31:0] m;} fwsr_exp_t;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, prot = 0, rd_d = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] bus, dq_o, d;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata, st;
	logic [21:0] flash_addr, a;
	logic dq_oe, ce_n, oe_n, we_n, ready_busy_n;
	int n_mismatch = 0, n_checks = 0;
	integer seed = 32'h6260f1a6;
	fwsr_exp_t q[$];
	fwsr_exp_t e;
	fwsr_host fwsr_host_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(bus), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_n(ready_busy_n));
	fwsr_flash_model fwsr_flash_model_inst (.clk(clk), .prot(prot), .flash_addr(flash_addr),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
		.flash_we_n(we_n), .bus(bus), .ready_busy_n(ready_busy_n));
	initial forever #20 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	// A zero mask marks a poll whose value is only used to steer the sequence.
	task automatic rd(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] m);
		q.push_back('{v, m});
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		@(posedge clk);
		st = reg_rdata;
	endtask
	task automatic start(input logic [21:0] ad, input logic [7:0] dat, input int op);
		wr(REG_ADDR, {10'h000, ad});
		wr(REG_DATA, {24'h00_0000, dat});
		wr(REG_CTRL, 32'h0000_0001 << op);
	endtask
	task automatic finish_op(input logic [31:0] v, input logic [31:0] m);
		int i;
		for (i = 0; i < 600; i++) begin
			rd(REG_STAT, 32'h0000_0000, 32'h0000_0000);
			if (st[STAT_BUSY] === 1'b0) break;
		end
		if (i == 600) begin
			n_mismatch++;
			print_verdict();
		end
		rd(REG_STAT, v, m);
	endtask
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) begin
			e = q.pop_front();
			if (e.m != 0) check(reg_rdata & e.m, e.v);
		end
	end
	// The whole sequence needs under a thousand cycles; this limit of 20000 cycles is far beyond that.
	initial begin
		#800000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		rd(REG_STAT, 32'h0000_0008, 32'hffff_ffff);
		rd(8'h10, 32'h0000_0000, 32'hffff_ffff);
		a = {10'h000, 12'($random(seed))};
		d = 8'($random(seed)) & 8'hfe;
		start(a, d, CTRL_PROG);
		repeat (30) @(posedge clk);
		rd(REG_STAT, {8'h00, ~d[7], 23'h00_0001}, 32'h00bf_000f);
		wr(REG_ADDR, 32'h0000_1000);
		wr(REG_CTRL, 32'h0000_0002);
		rd(REG_ADDR, {10'h000, a}, 32'hffff_ffff);
		finish_op({16'h0000, d, 8'h0a}, 32'h0000_ff1f);
		start(a, ~d, CTRL_PROG);
		finish_op(32'h0000_0006, 32'h0000_0007);
		start(a, d, CTRL_PROG);
		finish_op({16'h0000, d, 8'h0a}, 32'h0000_ff1f);
		prot <= 1;
		start(a + 22'h00_0001, 8'h00, CTRL_PROG);
		finish_op(32'h0000_ff06, 32'h0000_ff07);
		start(22'h00_1000, 8'h00, CTRL_ERASE);
		finish_op(32'h0000_ff0a, 32'h0000_ff1f);
		prot <= 0;
		start(a, 8'h00, CTRL_ERASE);
		repeat (40) @(posedge clk);
		wr(REG_CTRL, 32'h0000_0008);
		repeat (150) @(posedge clk);
		rd(REG_STAT, 32'h0008_0010, 32'h00bb_0010);
		rd(REG_CTRL, 32'h0000_0008, 32'hffff_ffff);
		wr(REG_CTRL, 32'h0000_0000);
		finish_op(32'h0000_ff0a, 32'h0000_ff1f);
		wr(REG_CTRL, 32'h0000_0004);
		finish_op(32'h0000_0002, 32'h0000_0007);
		print_verdict();
	end
endmodule

/* File: core/fwsr_host.sv */
// How it works
// - Bit 7 may settle early; reread all.
// - Poll at program or erasing sector address.
// - Read twice, compare toggle, then read data.
// - Toggling with limit flag: recheck, else fail.
// - Resumed monitoring restarts from first read.
// - Recheck bit 7 even after limit flag.
// - After a limit failure issue the reset command; a bit 7 failure just ends.
// - Reset is one write of F0.
// - Status reads address the busy bank.
`timescale 1ns/1ps
module fwsr_host import fwsr_pkg::*; #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Software register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Flash pins.
	output logic [ADDR_W-1:0] flash_addr,
	output logic [DATA_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [DATA_W-1:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	input wire logic ready_busy_n
);
	if (ADDR_W < 12 || ADDR_W > 32 || DATA_W != 8) begin : g_bad_params
		$error("fwsr_host supports byte mode with 12 to 32 address bits only");
	end

	fwsr_state_t state_ff, nxt_state;
	fwsr_op_t op_ff, nxt_op;
	fwsr_poll_t poll_ff, nxt_poll;
	logic [2:0] idx_ff, nxt_idx;
	logic [3:0] cnt_ff, nxt_cnt;
	logic prev_tog_ff, nxt_prev_tog;
	logic done_ff, nxt_done;
	logic fail_ff, nxt_fail;
	logic pause_ff, nxt_pause;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [7:0] data_ff, nxt_data;
	logic [7:0] rd_ff, nxt_rd;
	logic [7:0] result_ff, nxt_result;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [ADDR_W-1:0] pin_addr_ff, nxt_pin_addr;
	logic [7:0] pin_dq_ff, nxt_pin_dq;
	logic pin_oe_ff, nxt_pin_oe;
	logic ce_n_ff, nxt_ce_n;
	logic oe_n_ff, nxt_oe_n;
	logic we_n_ff, nxt_we_n;
	logic [8:0] sync_out;
	logic [7:0] dq_sync;
	logic rdy_sync;
	logic [ADDR_W-1:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [2:0] last_idx;
	logic tog;
	logic lim;
	logic wr_ctrl;
	logic idle;

	fwsr_sync #(.WIDTH(9)) u_sync (
		.clk(clk),
		.rst(rst),
		.din({ready_busy_n, flash_dq_i}),
		.dout(sync_out)
	);
	assign dq_sync = sync_out[7:0];
	assign rdy_sync = sync_out[8];
	assign idle = (state_ff == ST_IDLE);
	assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
	assign tog = rd_ff[TOGGLE_BIT_ONE];
	assign lim = rd_ff[TIMING_LIMIT_FLAG];

	// Address and data of the current command write cycle.
	always_comb begin
		cmd_addr = ADDR_W'(CMD_ADDR_A);
		cmd_data = CMD_UNLOCK1;
		last_idx = LAST_PROG;
		case (op_ff)
			OP_PROG: begin
				last_idx = LAST_PROG;
				case (idx_ff)
					3'h0: cmd_data = CMD_UNLOCK1;
					3'h1: begin
						cmd_addr = ADDR_W'(CMD_ADDR_5);
						cmd_data = CMD_UNLOCK2;
					end
					3'h2: cmd_data = CMD_PROGRAM;
					default: begin
						cmd_addr = addr_ff;
						cmd_data = data_ff;
					end
				endcase
			end
			OP_ERASE: begin
				last_idx = LAST_ERASE;
				case (idx_ff)
					3'h0, 3'h3: cmd_data = CMD_UNLOCK1;
					3'h1, 3'h4: begin
						cmd_addr = ADDR_W'(CMD_ADDR_5);
						cmd_data = CMD_UNLOCK2;
					end
					3'h2: cmd_data = CMD_ERASE_SETUP;
					default: begin
						cmd_addr = addr_ff;
						cmd_data = CMD_SECTOR_ERASE;
					end
				endcase
			end
			default: begin
				last_idx = LAST_RESET;
				cmd_addr = addr_ff;
				cmd_data = CMD_RESET;
			end
		endcase
	end

	// Sequencer: command writes, then the toggle polling procedure.
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_poll = poll_ff;
		nxt_idx = idx_ff;
		nxt_cnt = cnt_ff;
		nxt_prev_tog = prev_tog_ff;
		nxt_done = done_ff;
		nxt_fail = fail_ff;
		nxt_rd = rd_ff;
		nxt_result = result_ff;
		nxt_pause = wr_ctrl ? reg_wdata[CTRL_PAUSE] : pause_ff;
		nxt_addr = (reg_wr && idle && reg_addr == REG_ADDR) ? reg_wdata[ADDR_W-1:0] : addr_ff;
		nxt_data = (reg_wr && idle && reg_addr == REG_DATA) ? reg_wdata[7:0] : data_ff;
		case (state_ff)
			ST_IDLE: begin
				if (wr_ctrl && |reg_wdata[CTRL_RESET:CTRL_PROG]) begin
					nxt_op = reg_wdata[CTRL_PROG] ? OP_PROG :
						reg_wdata[CTRL_ERASE] ? OP_ERASE : OP_RESET;
					nxt_idx = 3'h0;
					nxt_done = 1'b0;
					nxt_fail = 1'b0;
					nxt_state = ST_WSET;
				end
			end
			ST_WSET: begin
				nxt_cnt = WE_LOW_CYC - 4'h1;
				nxt_state = ST_WLOW;
			end
			ST_WLOW: begin
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h0) begin
					nxt_cnt = WE_HIGH_CYC - 4'h1;
					nxt_state = ST_WREC;
				end
			end
			ST_WREC: begin
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h0) begin
					nxt_idx = idx_ff + 3'h1;
					nxt_state = ST_WSET;
					if (idx_ff == last_idx && op_ff == OP_RESET) begin
						nxt_done = 1'b1;
						nxt_state = ST_IDLE;
					end else if (idx_ff == last_idx) begin
						// Status is valid once the last write strobe has risen.
						nxt_poll = PL_FIRST;
						nxt_cnt = RD_CYC - 4'h1;
						nxt_state = ST_RLOW;
					end
				end
			end
			ST_RLOW: begin
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h0) begin
					nxt_state = ST_RCAP;
				end
			end
			ST_RCAP: begin
				nxt_rd = dq_sync;
				nxt_state = ST_EVAL;
			end
			ST_EVAL: begin
				nxt_cnt = RD_CYC - 4'h1;
				nxt_state = ST_RLOW;
				nxt_prev_tog = tog;
				if (pause_ff && poll_ff != PL_FINAL) begin
					nxt_state = ST_PAUSE;
				end else begin
					case (poll_ff)
						PL_FIRST: nxt_poll = PL_SECOND;
						PL_SECOND: begin
							if (tog == prev_tog_ff) begin
								nxt_poll = PL_FINAL;
							end else if (lim) begin
								nxt_poll = PL_LIMIT;
							end
						end
						PL_LIMIT: begin
							if (tog == prev_tog_ff) begin
								nxt_poll = PL_FINAL;
							end else begin
								// Still toggling after the limit flag: give up and reset.
								nxt_fail = 1'b1;
								nxt_op = OP_RESET;
								nxt_idx = 3'h0;
								nxt_state = ST_WSET;
							end
						end
						default: begin
							// Bit 7 is checked again on this fresh read of the array.
							nxt_result = rd_ff;
							nxt_fail = (op_ff == OP_PROG) ?
								rd_ff[COMPLEMENT_POLL_BIT] != data_ff[COMPLEMENT_POLL_BIT] :
								!rd_ff[COMPLEMENT_POLL_BIT];
							nxt_done = 1'b1;
							nxt_state = ST_IDLE;
						end
					endcase
				end
			end
			ST_PAUSE: begin
				if (!pause_ff) begin
					nxt_poll = PL_FIRST;
					nxt_cnt = RD_CYC - 4'h1;
					nxt_state = ST_RLOW;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Pin drive follows the sequencer state one cycle later.
	always_comb begin
		nxt_pin_addr = pin_addr_ff;
		nxt_pin_dq = pin_dq_ff;
		nxt_pin_oe = 1'b0;
		nxt_ce_n = 1'b1;
		nxt_oe_n = 1'b1;
		nxt_we_n = 1'b1;
		case (state_ff)
			ST_WSET, ST_WLOW, ST_WREC: begin
				nxt_pin_addr = cmd_addr;
				nxt_pin_dq = cmd_data;
				nxt_pin_oe = 1'b1;
				nxt_ce_n = 1'b0;
				nxt_we_n = (state_ff != ST_WLOW);
			end
			ST_RLOW, ST_RCAP: begin
				// Status is read at the programmed address or the erased sector.
				nxt_pin_addr = addr_ff;
				nxt_ce_n = 1'b0;
				nxt_oe_n = 1'b0;
			end
			default: nxt_pin_oe = 1'b0;
		endcase
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: nxt_rdata[CTRL_PAUSE] = pause_ff;
				REG_ADDR: nxt_rdata[ADDR_W-1:0] = addr_ff;
				REG_DATA: nxt_rdata[7:0] = data_ff;
				REG_STAT: begin
					nxt_rdata[STAT_BUSY] = !idle;
					nxt_rdata[STAT_DONE] = done_ff;
					nxt_rdata[STAT_FAIL] = fail_ff;
					nxt_rdata[STAT_RDY] = rdy_sync;
					nxt_rdata[STAT_PAUSE] = pause_ff;
					nxt_rdata[STAT_RES_LSB +: 8] = result_ff;
					nxt_rdata[STAT_RAW_LSB +: 8] = rd_ff;
				end
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_PROG;
			poll_ff <= PL_FIRST;
			idx_ff <= 3'h0;
			cnt_ff <= 4'h0;
			prev_tog_ff <= 1'b0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			pause_ff <= 1'b0;
			addr_ff <= '0;
			data_ff <= 8'h00;
			rd_ff <= 8'h00;
			result_ff <= 8'h00;
			rdata_ff <= 32'h0000_0000;
			pin_addr_ff <= '0;
			pin_dq_ff <= 8'h00;
			pin_oe_ff <= 1'b0;
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			poll_ff <= nxt_poll;
			idx_ff <= nxt_idx;
			cnt_ff <= nxt_cnt;
			prev_tog_ff <= nxt_prev_tog;
			done_ff <= nxt_done;
			fail_ff <= nxt_fail;
			pause_ff <= nxt_pause;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			rd_ff <= nxt_rd;
			result_ff <= nxt_result;
			rdata_ff <= nxt_rdata;
			pin_addr_ff <= nxt_pin_addr;
			pin_dq_ff <= nxt_pin_dq;
			pin_oe_ff <= nxt_pin_oe;
			ce_n_ff <= nxt_ce_n;
			oe_n_ff <= nxt_oe_n;
			we_n_ff <= nxt_we_n;
		end
	end

	assign reg_rdata = rdata_ff;
	assign flash_addr = pin_addr_ff;
	assign flash_dq_o = pin_dq_ff;
	assign flash_dq_oe = pin_oe_ff;
	assign flash_ce_n = ce_n_ff;
	assign flash_oe_n = oe_n_ff;
	assign flash_we_n = we_n_ff;

	// Reads since polling started, for checking only.
	logic [3:0] reads_ff;
	always_ff @(posedge clk) begin
		if (rst || (state_ff == ST_EVAL && nxt_poll == PL_FIRST) ||
			(state_ff != ST_EVAL && nxt_state == ST_RLOW && nxt_poll == PL_FIRST)) begin
			reads_ff <= 4'h0;
		end else if (state_ff == ST_RCAP && reads_ff != 4'hf) begin
			reads_ff <= reads_ff + 4'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_read_addr;
		!flash_oe_n |-> flash_addr == $past(addr_ff) && !flash_dq_oe;
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("status read off the poll address");

	property p_two_reads;
		(state_ff == ST_EVAL && poll_ff == PL_FINAL && !pause_ff) |-> reads_ff >= 4'h3;
	endproperty
	a_two_reads: assert property (p_two_reads) else $error("finished before two reads and a data read");

	property p_settle_reread;
		(state_ff == ST_EVAL && poll_ff == PL_SECOND && !pause_ff && tog == prev_tog_ff)
			|=> state_ff == ST_RLOW && poll_ff == PL_FINAL ##[1:20] state_ff == ST_RCAP;
	endproperty
	a_settle_reread: assert property (p_settle_reread) else $error("no data read after completion");

	property p_limit_fail;
		(state_ff == ST_EVAL && poll_ff == PL_LIMIT && !pause_ff && tog != prev_tog_ff)
			|=> fail_ff && op_ff == OP_RESET && state_ff == ST_WSET;
	endproperty
	a_limit_fail: assert property (p_limit_fail) else $error("limit failure without reset");

	property p_reset_write;
		(state_ff == ST_EVAL && poll_ff == PL_LIMIT && !pause_ff && tog != prev_tog_ff)
			|-> ##[2:6] (!flash_we_n && flash_dq_o == CMD_RESET && flash_dq_oe);
	endproperty
	a_reset_write: assert property (p_reset_write) else $error("reset command not written");

	property p_reset_single;
		(op_ff == OP_RESET && $fell(flash_we_n))
			|-> flash_dq_o == CMD_RESET ##1 !flash_we_n ##1 flash_we_n [*2];
	endproperty
	a_reset_single: assert property (p_reset_single) else $error("reset cycle data wrong");

	property p_resume_restart;
		(state_ff == ST_PAUSE && !pause_ff) |=> poll_ff == PL_FIRST && state_ff == ST_RLOW;
	endproperty
	a_resume_restart: assert property (p_resume_restart) else $error("resume skipped first read");

	property p_bit7_check;
		(state_ff == ST_EVAL && poll_ff == PL_FINAL && op_ff == OP_PROG)
			|=> done_ff && fail_ff == ($past(rd_ff[7]) != data_ff[7]);
	endproperty
	a_bit7_check: assert property (p_bit7_check) else $error("bit 7 not rechecked");

	property p_first_read;
		(state_ff == ST_WREC && cnt_ff == 4'h0 && idx_ff == last_idx && op_ff != OP_RESET)
			|-> ##2 (!flash_oe_n && flash_we_n);
	endproperty
	a_first_read: assert property (p_first_read) else $error("polling did not follow command");
endmodule

/* File: core/fwsr_pkg.sv */
package fwsr_pkg;

	// Register offsets of the controller's own register port.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;

	// Control register fields.
	localparam int CTRL_PROG = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_RESET = 2;
	localparam int CTRL_PAUSE = 3;

	// Status register fields.
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_FAIL = 2;
	localparam int STAT_RDY = 3;
	localparam int STAT_PAUSE = 4;
	localparam int STAT_RES_LSB = 8;
	localparam int STAT_RAW_LSB = 16;

	// Status bit positions within a byte read from the flash.
	localparam int COMPLEMENT_POLL_BIT = 7;
	localparam int TOGGLE_BIT_ONE = 6;
	localparam int TIMING_LIMIT_FLAG = 5;
	localparam int TOGGLE_BIT_TWO = 2;

	// Command cycle addresses and data in byte mode.
	localparam logic [11:0] CMD_ADDR_A = 12'haaa;
	localparam logic [11:0] CMD_ADDR_5 = 12'h555;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hf0;

	// Index of the last write cycle of each command sequence.
	localparam logic [2:0] LAST_PROG = 3'h3;
	localparam logic [2:0] LAST_ERASE = 3'h5;
	localparam logic [2:0] LAST_RESET = 3'h0;

	// Bus timing.
	localparam int CLK_MHZ = 25;
	localparam int WE_LOW_NS = 50;
	localparam int WE_HIGH_NS = 40;
	localparam int READ_ACC_NS = 100;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WE_HIGH_CYC = 4'((WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] RD_CYC = 4'((READ_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);

	typedef enum {ST_IDLE, ST_WSET, ST_WLOW, ST_WREC, ST_RLOW, ST_RCAP, ST_EVAL, ST_PAUSE}
		fwsr_state_t;
	typedef enum {OP_PROG, OP_ERASE, OP_RESET} fwsr_op_t;
	typedef enum {PL_FIRST, PL_SECOND, PL_LIMIT, PL_FINAL} fwsr_poll_t;

endpackage

/* File: core/fwsr_sync.sv */
`timescale 1ns/1ps
module fwsr_sync import fwsr_pkg::*; #(
	parameter int WIDTH = 9
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Asynchronous input and its synchronised copy.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	always_comb begin
		nxt_meta = din;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule
